// [hw/cm_params.svh]
// register indices, field positions, reset values and mode numbers
// of the counter module host port; included by the package
`ifndef CM_PARAMS_SVH
`define CM_PARAMS_SVH
`define CM_IDX_P01 8'h00
`define CM_IDX_P23 8'h04
`define CM_IDX_CTRL 8'h08
`define CM_IDX_STAT 8'h09
`define CM_IDX_MODE01 8'h0a
`define CM_IDX_MODE23 8'h0b
`define CM_IDX_MSTATE 8'h0c
`define CM_IDX_LSB 2
`define CM_IDX_MSB 9
`define CM_CTL_LD01 0
`define CM_CTL_CMP01 1
`define CM_CTL_LD23 2
`define CM_CTL_CMP23 3
`define CM_ST_KEEP 0
`define CM_ST_CLR 1
`define CM_STAT_RST 8'h02
`define CM_CTRL_RST 8'h00
`define CM_MODE_RST 8'h00
`define CM_RESP_OKAY 2'b00
`define CM_RESP_DECERR 2'b11
`define CM_M_CLKDIR 8'h00
`define CM_M_ENC1 8'h01
`define CM_M_ENC2 8'h03
`define CM_M_ENC4 8'h05
`define CM_M_DUAL_LO 8'h08
`define CM_M_DUAL_HI 8'h0b
`define CM_M_GATE_UP 8'h0c
`define CM_M_GATE_DN 8'h0d
`define CM_M_GATE_AR_UP 8'h0e
`define CM_M_GATE_AR_DN 8'h0f
`define CM_DUAL_LO_DN 0
`define CM_DUAL_HI_DN 1
`define CM_GATE_DN_BIT 0
`endif

// [hw/cm_pkg.sv]
// types and mode decoding of the counter module host port
// assumes cm_params.svh on the include path
package cm_pkg;
  `include "cm_params.svh"

  typedef enum logic [2:0] {
    MC_IDLE = 3'h0,
    MC_CLKDIR = 3'h1,
    MC_ENC1 = 3'h2,
    MC_ENC2 = 3'h3,
    MC_ENC4 = 3'h4,
    MC_DUAL = 3'h5,
    MC_GATE = 3'h6,
    MC_GATE_AR = 3'h7
  } cm_mclass_t;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_AW = 2'b01,
    WS_RESP = 2'b11,
    WS_WD = 2'b10
  } cm_wstate_t;

  typedef enum logic {
    RS_IDLE = 1'b0,
    RS_DATA = 1'b1
  } cm_rstate_t;

  function automatic cm_mclass_t cm_mode_class(input logic [7:0] m);
    cm_mclass_t c;
    c = MC_IDLE;
    if (m == `CM_M_CLKDIR) c = MC_CLKDIR;
    else if (m == `CM_M_ENC1) c = MC_ENC1;
    else if (m == `CM_M_ENC2) c = MC_ENC2;
    else if (m == `CM_M_ENC4) c = MC_ENC4;
    else if (m >= `CM_M_DUAL_LO && m <= `CM_M_DUAL_HI) c = MC_DUAL;
    else if (m == `CM_M_GATE_UP || m == `CM_M_GATE_DN) c = MC_GATE;
    else if (m == `CM_M_GATE_AR_UP || m == `CM_M_GATE_AR_DN) c = MC_GATE_AR;
    return c;
  endfunction : cm_mode_class
endpackage : cm_pkg

// [hw/cm_sync.sv]
// two-flop synchroniser for the counter input pins
// assumes asynchronous pins and one system clock
`timescale 1ns/100ps
module cm_sync #(
  parameter int W = 6,
  parameter int STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] st_q [STAGES];

  if (STAGES < 2 || W < 1) begin : g_bad
    $error("cm_sync: STAGES must be at least 2");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '{default: '0};
    end else if (ce) begin
      st_q[0] <= d;
      for (int i = 1; i < STAGES; i++) st_q[i] <= st_q[i-1];
    end
  end

  assign q = st_q[STAGES-1];
endmodule : cm_sync

// [hw/cm_chan.sv]
// one counter pair: a 32-bit counter or two 16-bit halves
// assumes synchronised pins and single-cycle load strobes
`timescale 1ns/100ps
module cm_chan #(
  parameter int CW = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire cm_pkg::cm_mclass_t mclass,
  input wire logic [1:0] dir_bits,
  input wire logic res,
  input wire logic pa,
  input wire logic pb,
  input wire logic clear,
  input wire logic load_cnt,
  input wire logic load_cmp,
  input wire logic [CW-1:0] load_val,
  output logic [CW-1:0] count,
  output logic sw_out
);
  import cm_pkg::*;
  localparam int H = CW / 2;

  if (CW < 4 || CW % 2 != 0) begin : g_bad
    $error("cm_chan: CW must be even and at least 4");
  end

  logic [CW-1:0] cnt_q, cnt_d, cmp_q, rel_q;
  logic pa_q, pb_q, out_q;

  wire a_rise = pa & ~pa_q;
  wire b_rise = pb & ~pb_q;
  wire a_edge = pa ^ pa_q;
  wire b_edge = pb ^ pb_q;
  wire enc_up = ~(pa_q ^ pb);
  wire enc_go = (mclass == MC_ENC1 && a_rise) ||
    (mclass == MC_ENC2 && a_edge) ||
    (mclass == MC_ENC4 && (a_edge || b_edge));
  wire match = (cnt_q == cmp_q);
  wire gated = (mclass == MC_GATE || mclass == MC_GATE_AR);

  always_comb begin
    cnt_d = cnt_q;
    unique case (mclass)
      MC_CLKDIR: if (a_rise) cnt_d = pb ? cnt_q - 1'b1 : cnt_q + 1'b1;
      MC_ENC1, MC_ENC2, MC_ENC4: begin
        if (enc_go) cnt_d = enc_up ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
      MC_DUAL: begin
        // two independent halves, each clocked by its own pin
        if (a_rise) cnt_d[H-1:0] = dir_bits[`CM_DUAL_LO_DN] ?
          cnt_q[H-1:0] - 1'b1 : cnt_q[H-1:0] + 1'b1;
        if (b_rise) cnt_d[CW-1:H] = dir_bits[`CM_DUAL_HI_DN] ?
          cnt_q[CW-1:H] - 1'b1 : cnt_q[CW-1:H] + 1'b1;
      end
      MC_GATE, MC_GATE_AR: begin
        if (a_rise && pb) begin
          if (mclass == MC_GATE_AR && match) cnt_d = rel_q;
          else cnt_d = dir_bits[`CM_GATE_DN_BIT] ?
            cnt_q - 1'b1 : cnt_q + 1'b1;
        end
      end
      MC_IDLE: cnt_d = cnt_q;
    endcase
    if (res && mclass != MC_DUAL && mclass != MC_IDLE) cnt_d = '0;
    if (load_cnt) cnt_d = load_val;
    if (clear) cnt_d = '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      cmp_q <= '0;
      rel_q <= '0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      out_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      pa_q <= pa;
      pb_q <= pb;
      if (load_cmp) cmp_q <= load_val;
      if (load_cnt) rel_q <= load_val;
      out_q <= gated && match;
    end
  end

  assign count = cnt_q;
  assign sw_out = out_q;
endmodule : cm_chan

// [hw/cm_top.sv]
// counter module host data port: AXI4-Lite image, control, modes
// assumes master_restart comes from logic on aclk; pins are async
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module cm_top #(
  parameter int ADDR_W = 12,
  parameter int CW = 32,
  parameter int SYNC_STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic master_restart,
  input wire logic [5:0] cnt_in,
  output logic sw_out0,
  output logic sw_out1,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cm_pkg::*;

  // refuse parameters the register map or the pin synchroniser cannot serve
  if (ADDR_W < `CM_IDX_MSB + 1) begin : g_bad_addr
    $error("cm_top: ADDR_W too narrow for the register map");
  end
  if (CW != 32) begin : g_bad_cw
    $error("cm_top: CW must be 32");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("cm_top: SYNC_STAGES must be at least 2");
  end

  // register index of a byte address
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[`CM_IDX_MSB:`CM_IDX_LSB];
  endfunction : idx_of

  // address lies on a mapped register word
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = idx_of(a);
    return ((a >> (`CM_IDX_MSB + 1)) == '0) &&
      (i == `CM_IDX_P01 || i == `CM_IDX_P23 ||
       i == `CM_IDX_CTRL || i == `CM_IDX_STAT ||
       i == `CM_IDX_MODE01 || i == `CM_IDX_MODE23 ||
       i == `CM_IDX_MSTATE);
  endfunction : mapped

  // pins
  logic [5:0] pin_s;

  cm_sync #(
    .W(6),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(cnt_in),
    .q(pin_s)
  );

  // image and parameter registers
  logic [31:0] load01_q, load23_q;
  logic [7:0] ctrl_q, stat_q, mode01_q, mode23_q;
  logic [31:0] cnt01, cnt23;
  logic out01, out23;

  // write channel state
  cm_wstate_t ws_q, ws_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  wire ws_idle = (ws_q == WS_IDLE);
  wire ws_aw = (ws_q == WS_AW);
  wire ws_wd = (ws_q == WS_WD);
  wire ws_resp = (ws_q == WS_RESP);

  assign s_axi_awready = ce & (ws_idle | ws_wd);
  assign s_axi_wready = ce & (ws_idle | ws_aw);
  assign s_axi_bvalid = ce & ws_resp;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire b_hs = s_axi_bvalid & s_axi_bready;

  always_comb begin
    ws_d = ws_q;
    unique case (ws_q)
      WS_IDLE: begin
        if (aw_hs && w_hs) ws_d = WS_RESP;
        else if (aw_hs) ws_d = WS_AW;
        else if (w_hs) ws_d = WS_WD;
      end
      WS_AW: if (w_hs) ws_d = WS_RESP;
      WS_WD: if (aw_hs) ws_d = WS_RESP;
      WS_RESP: if (b_hs) ws_d = WS_IDLE;
    endcase
  end

  // the write lands in the cycle both halves are complete
  wire wr_go = (ws_d == WS_RESP) && (ws_q != WS_RESP);
  wire [ADDR_W-1:0] wa = aw_hs ? s_axi_awaddr : awaddr_q;
  wire [31:0] wd = w_hs ? s_axi_wdata : wdata_q;
  wire [3:0] wb = w_hs ? s_axi_wstrb : wstrb_q;
  wire [7:0] w_idx = idx_of(wa);
  wire w_ok = mapped(wa);

  wire hit_p01 = wr_go && w_ok && w_idx == `CM_IDX_P01;
  wire hit_p23 = wr_go && w_ok && w_idx == `CM_IDX_P23;
  wire hit_ctrl = wr_go && w_ok && w_idx == `CM_IDX_CTRL && wb[0];
  wire hit_stat = wr_go && w_ok && w_idx == `CM_IDX_STAT && wb[0];
  wire hit_m01 = wr_go && w_ok && w_idx == `CM_IDX_MODE01 && wb[0];
  wire hit_m23 = wr_go && w_ok && w_idx == `CM_IDX_MODE23 && wb[0];

  // bits that went 0 to 1 against the last control byte
  wire [7:0] ctrl_rise = hit_ctrl ? (wd[7:0] & ~ctrl_q) : 8'h00;

  wire ld_cnt01 = ctrl_rise[`CM_CTL_LD01];
  wire ld_cmp01 = ctrl_rise[`CM_CTL_CMP01];
  wire ld_cnt23 = ctrl_rise[`CM_CTL_LD23];
  wire ld_cmp23 = ctrl_rise[`CM_CTL_CMP23];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_q <= WS_IDLE;
    end else if (ce) begin
      ws_q <= ws_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
    end else if (ce && aw_hs) begin
      awaddr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce && w_hs) begin
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  // response code fixed in the cycle the write lands
  logic [1:0] bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_q <= `CM_RESP_OKAY;
    end else if (ce && wr_go) begin
      bresp_q <= w_ok ? `CM_RESP_OKAY : `CM_RESP_DECERR;
    end
  end

  assign s_axi_bresp = bresp_q;

  // staged output image, one byte lane at a time
  genvar gb;
  for (gb = 0; gb < 4; gb++) begin : g_lane01
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        load01_q[8*gb +: 8] <= 8'h00;
      end else if (ce && hit_p01 && wb[gb]) begin
        load01_q[8*gb +: 8] <= wd[8*gb +: 8];
      end
    end
  end

  for (gb = 0; gb < 4; gb++) begin : g_lane23
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        load23_q[8*gb +: 8] <= 8'h00;
      end else if (ce && hit_p23 && wb[gb]) begin
        load23_q[8*gb +: 8] <= wd[8*gb +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CM_CTRL_RST;
    end else if (ce && hit_ctrl) begin
      ctrl_q <= wd[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= `CM_STAT_RST;
    end else if (ce && hit_stat) begin
      stat_q <= wd[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode01_q <= `CM_MODE_RST;
    end else if (ce && hit_m01) begin
      mode01_q <= wd[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode23_q <= `CM_MODE_RST;
    end else if (ce && hit_m23) begin
      mode23_q <= wd[7:0];
    end
  end

  // restart handling
  wire keep = stat_q[`CM_ST_KEEP] & ~stat_q[`CM_ST_CLR];
  wire clr_cnt = master_restart & ~keep;

  // mode decode per pair
  cm_mclass_t cls01, cls23;
  assign cls01 = cm_mode_class(mode01_q);
  assign cls23 = cm_mode_class(mode23_q);

  // pins 1..3 serve pair 0/1, pins 4..6 pair 2/3
  cm_chan #(
    .CW(CW)
  ) u_pair01 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .mclass(cls01),
    .dir_bits(mode01_q[1:0]),
    .res(pin_s[0]),
    .pa(pin_s[1]),
    .pb(pin_s[2]),
    .clear(clr_cnt),
    .load_cnt(ld_cnt01),
    .load_cmp(ld_cmp01),
    .load_val(load01_q),
    .count(cnt01),
    .sw_out(out01)
  );

  cm_chan #(
    .CW(CW)
  ) u_pair23 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .mclass(cls23),
    .dir_bits(mode23_q[1:0]),
    .res(pin_s[3]),
    .pa(pin_s[4]),
    .pb(pin_s[5]),
    .clear(clr_cnt),
    .load_cnt(ld_cnt23),
    .load_cmp(ld_cmp23),
    .load_val(load23_q),
    .count(cnt23),
    .sw_out(out23)
  );

  assign sw_out0 = out01;
  assign sw_out1 = out23;

  // read channel
  cm_rstate_t rs_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign s_axi_arready = ce & (rs_q == RS_IDLE);
  assign s_axi_rvalid = ce & (rs_q == RS_DATA);

  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire r_hs = s_axi_rvalid & s_axi_rready;
  wire [7:0] r_idx = idx_of(s_axi_araddr);
  wire r_ok = mapped(s_axi_araddr);
  wire [31:0] mstate = {16'h0000, 5'h00, cls23, 5'h00, cls01};

  wire rh_p01 = (r_idx == `CM_IDX_P01);
  wire rh_p23 = (r_idx == `CM_IDX_P23);
  wire rh_stat = (r_idx == `CM_IDX_CTRL) || (r_idx == `CM_IDX_STAT);
  wire rh_m01 = (r_idx == `CM_IDX_MODE01);
  wire rh_m23 = (r_idx == `CM_IDX_MODE23);

  wire [31:0] rd_mux =
    !r_ok ? 32'h0000_0000 :
    rh_p01 ? cnt01 :
    rh_p23 ? cnt23 :
    rh_stat ? {24'h000000, stat_q} :
    rh_m01 ? {24'h000000, mode01_q} :
    rh_m23 ? {24'h000000, mode23_q} :
    mstate;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_q <= RS_IDLE;
    end else if (ce) begin
      unique case (rs_q)
        RS_IDLE: if (ar_hs) rs_q <= RS_DATA;
        RS_DATA: if (r_hs) rs_q <= RS_IDLE;
      endcase
    end
  end

  // read word captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CM_RESP_OKAY;
    end else if (ce && ar_hs) begin
      rdata_q <= rd_mux;
      rresp_q <= r_ok ? `CM_RESP_OKAY : `CM_RESP_DECERR;
    end
  end

  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : cm_top

// [bench/cm_checker.sv]
// protocol checker of the cm_top AXI4-Lite slave port
// bound into cm_top; sees only its ports
`timescale 1ns/100ps
`include "cm_params.svh"
module cm_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata dropped");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read late");
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write late");
  property p_rblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rblk: assert property (p_rblk) else $error("read overlap");
  property p_wblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblk: assert property (p_wblk) else $error("write overlap");
  property p_ce;
    !ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready || s_axi_rvalid);
  endproperty
  a_ce: assert property (p_ce) else $error("bus live when frozen");
  property p_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_done: assert property (p_done) else $error("read repeated");
  property p_rerr;
    s_axi_rvalid && s_axi_rresp != `CM_RESP_OKAY |-> s_axi_rdata == 32'h0;
  endproperty
  a_rerr: assert property (p_rerr) else $error("error read data");
endmodule : cm_checker

bind cm_top cm_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

// [bench/cm_host.sv]
// bus master model standing in for the backplane coupler
// assumes a slave on aclk; hangs are cut by the bench timeout
`timescale 1ns/100ps
module cm_host (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 12'h000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
  end
  // released lines show the inverse of their last value
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_awaddr <= ~a;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tw) s_axi_wdata <= ~d;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
endmodule : cm_host

// [bench/tb.sv]
// self-checking bench of cm_top driven through the bus master model
// assumes cm_host answers the bus; pins and restart driven here
`timescale 1ns/100ps
`include "cm_params.svh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic master_restart = 1'b0;
  logic [5:0] cnt_in = 6'h00;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] prot = 3'h0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, w, v2, x;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, sw0, sw1;
  logic arvalid, arready, rvalid, rready;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] mtab[8] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h0f,
    8'h10};
  logic [2:0] ctab[8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  cm_top #(.ADDR_W(12), .CW(32), .SYNC_STAGES(2)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .master_restart(master_restart), .cnt_in(cnt_in),
    .sw_out0(sw0), .sw_out1(sw1), .s_axi_awaddr(awaddr),
    .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  cm_host u_host (
    .aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  initial forever #20 aclk = ~aclk;
  task chk(input string nm, input logic [33:0] seen, input logic [33:0] e);
    num_checks++;
    if (seen !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("read", {rresp, rdata}, rq.size() ? rq.pop_front() : 'x);
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk("bresp", {32'h0, bresp}, bq.size() ? bq.pop_front() : 'x);
    end
  end
  task wrx(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    u_host.wr({2'b00, i, 2'b00}, d);
  endtask : wrx
  task rdx(input logic [7:0] i, input logic [33:0] e);
    rq.push_back(e);
    u_host.rd({2'b00, i, 2'b00});
  endtask : rdx
  task restart;
    master_restart <= 1'b1;
    @(posedge aclk);
    master_restart <= 1'b0;
    @(posedge aclk);
  endtask : restart
  initial begin
    void'($urandom(32'h0b44));
    prot <= 3'($urandom);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdx(`CM_IDX_STAT, {26'h0, `CM_STAT_RST});
    rdx(`CM_IDX_CTRL, {26'h0, `CM_STAT_RST});
    for (int i = 0; i < 8; i++) begin
      wrx(`CM_IDX_MODE01, {24'h0, mtab[i]}, `CM_RESP_OKAY);
      wrx(`CM_IDX_MODE23, {24'h0, mtab[7-i]}, `CM_RESP_OKAY);
      rdx(`CM_IDX_MODE01, {26'h0, mtab[i]});
      rdx(`CM_IDX_MSTATE, {23'h0, ctab[7-i], 5'h0, ctab[i]});
    end
    wrx(`CM_IDX_MODE01, 32'h0, `CM_RESP_OKAY);
    wrx(`CM_IDX_MODE23, 32'h0, `CM_RESP_OKAY);
    v = $urandom;
    w = $urandom;
    v2 = $urandom;
    wrx(`CM_IDX_P01, v, `CM_RESP_OKAY);
    wrx(`CM_IDX_P23, w, `CM_RESP_OKAY);
    wrx(`CM_IDX_CTRL, 32'h1, `CM_RESP_OKAY);
    rdx(`CM_IDX_P01, {2'b00, v});
    rdx(`CM_IDX_P23, 34'h0);
    wrx(`CM_IDX_CTRL, 32'h5, `CM_RESP_OKAY);
    rdx(`CM_IDX_P23, {2'b00, w});
    wrx(`CM_IDX_P01, v2, `CM_RESP_OKAY);
    wrx(`CM_IDX_CTRL, 32'h5, `CM_RESP_OKAY);
    rdx(`CM_IDX_P01, {2'b00, v});
    wrx(`CM_IDX_CTRL, 32'h4, `CM_RESP_OKAY);
    wrx(`CM_IDX_CTRL, 32'h5, `CM_RESP_OKAY);
    rdx(`CM_IDX_P01, {2'b00, v2});
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    repeat (3) begin
      cnt_in <= 6'h12;
      repeat (4) @(posedge aclk);
      cnt_in <= 6'h00;
      repeat (4) @(posedge aclk);
    end
    rdx(`CM_IDX_P01, {2'b00, v2 + 32'h3});
    rdx(`CM_IDX_P23, {2'b00, w + 32'h3});
    x = w + 32'h3;
    wrx(`CM_IDX_MODE01, {24'h0, `CM_M_GATE_UP}, `CM_RESP_OKAY);
    wrx(`CM_IDX_MODE23, {24'h0, `CM_M_DUAL_LO}, `CM_RESP_OKAY);
    wrx(`CM_IDX_P01, 32'h3, `CM_RESP_OKAY);
    wrx(`CM_IDX_CTRL, 32'h7, `CM_RESP_OKAY);
    wrx(`CM_IDX_P01, 32'h0, `CM_RESP_OKAY);
    wrx(`CM_IDX_CTRL, 32'h4, `CM_RESP_OKAY);
    wrx(`CM_IDX_CTRL, 32'h5, `CM_RESP_OKAY);
    @(negedge aclk);
    chk("sw_out0", {33'h0, sw0}, 34'h0);
    @(posedge aclk);
    cnt_in <= 6'h04;
    repeat (4) @(posedge aclk);
    repeat (3) begin
      cnt_in <= 6'h36;
      repeat (4) @(posedge aclk);
      cnt_in <= 6'h04;
      repeat (4) @(posedge aclk);
    end
    @(negedge aclk);
    chk("sw_out0", {33'h0, sw0}, 34'h1);
    chk("sw_out1", {33'h0, sw1}, 34'h0);
    @(posedge aclk);
    cnt_in <= 6'h00;
    rdx(`CM_IDX_P01, 34'h3);
    rdx(`CM_IDX_P23, {2'b00, x[31:16] + 16'h3, x[15:0] + 16'h3});
    restart();
    rdx(`CM_IDX_P01, 34'h0);
    rdx(`CM_IDX_P23, 34'h0);
    wrx(`CM_IDX_STAT, 32'h1, `CM_RESP_OKAY);
    rdx(`CM_IDX_STAT, 34'h1);
    wrx(`CM_IDX_P01, v, `CM_RESP_OKAY);
    wrx(`CM_IDX_CTRL, 32'h4, `CM_RESP_OKAY);
    wrx(`CM_IDX_CTRL, 32'h5, `CM_RESP_OKAY);
    restart();
    rdx(`CM_IDX_P01, {2'b00, v});
    wrx(`CM_IDX_STAT, 32'h3, `CM_RESP_OKAY);
    restart();
    rdx(`CM_IDX_P01, 34'h0);
    wrx(8'h10, 32'hffffffff, `CM_RESP_DECERR);
    rdx(8'h10, {`CM_RESP_DECERR, 32'h0});
    wstrb <= 4'h0;
    wrx(`CM_IDX_STAT, 32'h1, `CM_RESP_OKAY);
    wstrb <= 4'hf;
    rdx(`CM_IDX_STAT, 34'h3);
    repeat (4) @(posedge aclk);
    stop_test();
  end
endmodule : tb
